// file: inc/cti_pkg.sv
// Purpose: shared constants and types for the transmit-port interrupt logic
// Assumes: 8-bit register interface, one register clock
// Notes: offsets are byte addresses of the register interface
package cti_pkg;
   localparam logic [7:0] CTI_ADDR_PORT_SEL = 8'h32;
   localparam logic [7:0] CTI_ADDR_LIVE_STS = 8'h35;
   localparam logic [7:0] CTI_ADDR_IRQ_EN = 8'h36;
   localparam logic [7:0] CTI_ADDR_IRQ_ST = 8'h37;
   localparam logic [7:0] CTI_RST_VAL = 8'h00;
   localparam logic [7:0] CTI_ZERO8 = 8'h00;
   // writable / meaningful bits 4:0 of enable and status
   localparam logic [7:0] CTI_FIELD_MASK = 8'h1F;
   // bit positions shared by enable and status
   localparam int CTI_B_FWD_IRQ = 4;
   localparam int CTI_B_SYNC_FAULT = 3;
   localparam int CTI_B_SYNCED = 2;
   localparam int CTI_B_PASS_DROP = 1;
   localparam int CTI_B_PASS = 0;
   // live status layout
   localparam int CTI_B_LIVE_PORT = 4;
   localparam int CTI_B_LIVE_SYNC = 1;
   localparam int CTI_B_LIVE_PASS = 0;

   // per transmit port control and event inputs
   typedef struct packed {
      logic sync_en;    // stream synchronization enabled in forwarding control
      logic sync_ok;    // raw synchronizer lock from the forwarding engine
      logic sync_err;   // one-cycle synchronization error event
      logic pass_all;   // all-ports pass mode
   } cti_tx_cfg_t;

   // register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cti_req_t;
endpackage

// file: src/cti_port_slice.sv
// Purpose: enable and latched status for one transmit port
// Assumes: event inputs come from logic on sys_clk
// Notes: status read-clear and events may coincide; the event wins
module cti_port_slice
   import cti_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register side
   input wire logic en_wr,
   input wire logic [7:0] wdata,
   input wire logic st_rd_clr,
   // events and live levels
   input wire logic fwd_irq,
   input wire logic live_sync,
   input wire logic live_pass,
   input wire logic sync_fault_ev,
   input wire logic pass_drop_ev,
   // results
   output logic [7:0] en_q,
   output logic [7:0] st,
   output logic irq
);
   logic [7:0] en_d;
   logic [3:0] lat_q, lat_d;
   logic sync_prev_q, sync_prev_d;
   logic pass_prev_q, pass_prev_d;
   logic [3:0] set_v;

   // next state: sticky bits, set beats the clearing read
   always_comb begin
      en_d = en_q;
      if (en_wr) begin
         en_d = wdata & CTI_FIELD_MASK;
      end
      set_v = '0;
      set_v[CTI_B_SYNC_FAULT] = sync_fault_ev;
      set_v[CTI_B_SYNCED] = live_sync & ~sync_prev_q;
      set_v[CTI_B_PASS_DROP] = pass_drop_ev;
      set_v[CTI_B_PASS] = live_pass & ~pass_prev_q;
      lat_d = (st_rd_clr ? 4'h0 : lat_q) | set_v;
      sync_prev_d = live_sync;
      pass_prev_d = live_pass;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= CTI_RST_VAL;
         lat_q <= 4'h0;
         sync_prev_q <= 1'b0;
         pass_prev_q <= 1'b0;
      end else begin
         en_q <= en_d;
         lat_q <= lat_d;
         sync_prev_q <= sync_prev_d;
         pass_prev_q <= pass_prev_d;
      end
   end

   // bit 4 is live: cleared only at the receive port, reserved bits zero
   assign st = {3'b000, fwd_irq, lat_q};
   // combined request; each bit gated by its own enable
   assign irq = |(st & en_q);

   property p_synced_latch;
      @(posedge sys_clk) disable iff (!rst_n) $rose(live_sync) |=> st[CTI_B_SYNCED];
   endproperty
   a_synced_latch: assert property (p_synced_latch) else $error("synced edge not latched");

   property p_pass_latch;
      @(posedge sys_clk) disable iff (!rst_n) $rose(live_pass) |=> st[CTI_B_PASS];
   endproperty
   a_pass_latch: assert property (p_pass_latch) else $error("pass edge not latched");

   property p_fault_latch;
      @(posedge sys_clk) disable iff (!rst_n) sync_fault_ev |=> st[CTI_B_SYNC_FAULT];
   endproperty
   a_fault_latch: assert property (p_fault_latch) else $error("sync fault lost");

   property p_drop_latch;
      @(posedge sys_clk) disable iff (!rst_n) pass_drop_ev |=> st[CTI_B_PASS_DROP] [*1];
   endproperty
   a_drop_latch: assert property (p_drop_latch) else $error("pass drop lost");

   property p_fault_clear;
      @(posedge sys_clk) disable iff (!rst_n)
         (st_rd_clr && !sync_fault_ev) |=> !st[CTI_B_SYNC_FAULT];
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared by read");

   property p_fault_hold;
      @(posedge sys_clk) disable iff (!rst_n)
         (st[CTI_B_SYNC_FAULT] && !st_rd_clr) |=> st[CTI_B_SYNC_FAULT];
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without read");

   property p_irq_level;
      @(posedge sys_clk) disable iff (!rst_n)
         (en_q[CTI_B_FWD_IRQ] && fwd_irq) |-> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("forwarded irq not raised");
endmodule

// file: src/cti_tx_irq.sv
// Purpose: interrupt logic of all CSI-2 transmit ports behind the register interface
// Assumes: request and event inputs are synchronous to sys_clk
// Notes: read data is registered and valid one cycle after the read strobe
module cti_tx_irq
   import cti_pkg::*;
#(
   parameter int N_TX = 2,
   parameter int N_RX = 4
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register access
   input wire cti_req_t req,
   output logic [7:0] rdata_q,
   output logic rvalid_q,
   // receive-port inputs
   input wire logic [N_RX-1:0] rx_enabled,
   input wire logic [N_RX-1:0] rx_valid,
   input wire logic [N_RX-1:0] rx_irq,
   input wire logic [N_TX-1:0][N_RX-1:0] rx_fwd_map,
   // transmit-port inputs
   input wire cti_tx_cfg_t [N_TX-1:0] tx_cfg,
   // interrupt request and live pass / sync outputs
   output logic [N_TX-1:0] tx_irq,
   output logic [N_TX-1:0] tx_pass,
   output logic [N_TX-1:0] tx_sync
);
   localparam int SEL_W = (N_TX > 1) ? $clog2(N_TX) : 1;

   logic [SEL_W-1:0] sel_q, sel_d;
   logic [7:0] rdata_d;
   logic rvalid_d;
   logic [N_RX-1:0] valid_prev_q, valid_prev_d;
   logic [N_TX-1:0][7:0] en_arr;
   logic [N_TX-1:0][7:0] st_arr;
   logic [N_TX-1:0] en_wr;
   logic [N_TX-1:0] st_clr;
   logic [N_TX-1:0] drop_ev;
   logic [N_TX-1:0] fwd_irq;

   // pass over the enabled forwarded receive ports
   function automatic logic pass_of(input logic [N_RX-1:0] valid,
                                    input logic [N_RX-1:0] mask,
                                    input logic all_mode);
      logic r;
      if (all_mode) begin
         r = (|mask) && (&(valid | ~mask));
      end else begin
         r = |(valid & mask);
      end
      return r;
   endfunction

   // per-port derived levels and events
   always_comb begin
      for (int t = 0; t < N_TX; t++) begin
         tx_pass[t] = pass_of(rx_valid, rx_enabled & rx_fwd_map[t], tx_cfg[t].pass_all);
         tx_sync[t] = tx_cfg[t].sync_en & tx_cfg[t].sync_ok;
         drop_ev[t] = |(valid_prev_q & ~rx_valid & rx_fwd_map[t]);
         fwd_irq[t] = |(rx_irq & rx_fwd_map[t]);
         en_wr[t] = req.wr && (req.addr == CTI_ADDR_IRQ_EN) && (sel_q == SEL_W'(t));
         st_clr[t] = req.rd && (req.addr == CTI_ADDR_IRQ_ST) && (sel_q == SEL_W'(t));
      end
   end

   generate
      for (genvar g = 0; g < N_TX; g++) begin : g_port
         cti_port_slice u_slice (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .en_wr(en_wr[g]),
            .wdata(req.wdata),
            .st_rd_clr(st_clr[g]),
            .fwd_irq(fwd_irq[g]),
            .live_sync(tx_sync[g]),
            .live_pass(tx_pass[g]),
            .sync_fault_ev(tx_cfg[g].sync_err),
            .pass_drop_ev(drop_ev[g]),
            .en_q(en_arr[g]),
            .st(st_arr[g]),
            .irq(tx_irq[g])
         );
      end
   endgenerate

   // register decode; unmapped addresses read zero and ignore writes
   always_comb begin
      sel_d = sel_q;
      if (req.wr && (req.addr == CTI_ADDR_PORT_SEL)) begin
         sel_d = req.wdata[SEL_W-1:0];
      end
      rdata_d = rdata_q;
      rvalid_d = req.rd;
      if (req.rd) begin
         rdata_d = CTI_ZERO8;
         unique case (req.addr)
            CTI_ADDR_PORT_SEL: rdata_d[SEL_W-1:0] = sel_q;
            CTI_ADDR_LIVE_STS: begin
               rdata_d[CTI_B_LIVE_PORT] = sel_q[0];
               rdata_d[CTI_B_LIVE_SYNC] = tx_sync[sel_q];
               rdata_d[CTI_B_LIVE_PASS] = tx_pass[sel_q];
            end
            CTI_ADDR_IRQ_EN: rdata_d = en_arr[sel_q];
            CTI_ADDR_IRQ_ST: rdata_d = st_arr[sel_q];
            default: rdata_d = CTI_ZERO8;
         endcase
      end
      valid_prev_d = rx_valid;
   end

   // a select beyond the last port would alias; software must keep it in range
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= '0;
         rdata_q <= CTI_RST_VAL;
         rvalid_q <= 1'b0;
         valid_prev_q <= '0;
      end else begin
         sel_q <= sel_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         valid_prev_q <= valid_prev_d;
      end
   end

   property p_st_read;
      @(posedge sys_clk) disable iff (!rst_n)
         (req.rd && req.addr == CTI_ADDR_IRQ_ST) |=> (rvalid_q && rdata_q == $past(st_arr[sel_q]));
   endproperty
   a_st_read: assert property (p_st_read) else $error("status read data wrong");

   property p_en_write;
      @(posedge sys_clk) disable iff (!rst_n)
         (req.wr && req.addr == CTI_ADDR_IRQ_EN) |=> en_arr[$past(sel_q)] == ($past(req.wdata) & CTI_FIELD_MASK);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write not stored");

   property p_reserved_zero;
      @(posedge sys_clk) disable iff (!rst_n)
         (req.rd && req.addr == CTI_ADDR_IRQ_ST) |=> rdata_q[7:5] == 3'b000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits set");

   property p_no_sync_when_off;
      @(posedge sys_clk) disable iff (!rst_n)
         (!tx_cfg[0].sync_en && $past(!tx_cfg[0].sync_en)) |=> !$rose(st_arr[0][CTI_B_SYNCED]);
   endproperty
   a_no_sync_when_off: assert property (p_no_sync_when_off) else $error("synced event while off");
endmodule

// file: verif/testbench.sv
// Purpose: self-checking bench for the transmit-port interrupt logic
// Assumes: two transmit ports, four receive ports, inputs driven on the falling edge
// Notes: expected values come from the register map; the whole run is about 130 cycles
module testbench
   import cti_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic sys_clk;
   logic rst_n;
   cti_req_t req;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic [3:0] rx_enabled;
   logic [3:0] rx_valid;
   logic [3:0] rx_irq;
   logic [1:0][3:0] rx_fwd_map;
   cti_tx_cfg_t [1:0] tx_cfg;
   logic [1:0] tx_irq;
   logic [1:0] tx_pass;
   logic [1:0] tx_sync;
   int fails;
   int comparisons;

   cti_tx_irq #(.N_TX(2), .N_RX(4)) cti_tx_irq_i (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .req(req),
      .rdata_q(rdata_q),
      .rvalid_q(rvalid_q),
      .rx_enabled(rx_enabled),
      .rx_valid(rx_valid),
      .rx_irq(rx_irq),
      .rx_fwd_map(rx_fwd_map),
      .tx_cfg(tx_cfg),
      .tx_irq(tx_irq),
      .tx_pass(tx_pass),
      .tx_sync(tx_sync)
   );

   // 20 MHz register clock
   always #25 sys_clk = ~sys_clk;

   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one-cycle write strobe, then an idle cycle so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      req = '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
      @(negedge sys_clk);
      req = '0;
   endtask

   // read data and valid are registered, so look one edge after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      req = '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00};
      @(negedge sys_clk);
      req = '0;
      chk("rvalid", {7'h00, rvalid_q}, 8'h01);
      chk("rdata", rdata_q, e);
   endtask

   // two cycles let edge detectors and latches settle
   task automatic tick;
      repeat (2) @(negedge sys_clk);
   endtask

   task automatic chk_irq(input logic e);
      chk("tx_irq0", {7'h00, tx_irq[0]}, {7'h00, e});
   endtask

   // hang guard: a stuck run still ends in the verdict
   initial begin
      #1000000;
      fails++;
      give_verdict();
   end

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      req = '0;
      rx_enabled = 4'h0;
      rx_valid = 4'h0;
      rx_irq = 4'h0;
      rx_fwd_map = '0;
      tx_cfg = '0;
      fails = 0;
      comparisons = 0;
      repeat (3) @(negedge sys_clk);
      rst_n = 1'b1;
      // reset values and per-port copies
      for (int p = 0; p < 2; p++) begin
         wr(CTI_ADDR_PORT_SEL, 8'(p));
         rd(CTI_ADDR_PORT_SEL, 8'(p));
         rd(CTI_ADDR_IRQ_EN, 8'h00);
         rd(CTI_ADDR_IRQ_ST, 8'h00);
      end
      wr(CTI_ADDR_IRQ_EN, 8'h0A);
      wr(CTI_ADDR_PORT_SEL, 8'h00);
      wr(CTI_ADDR_IRQ_EN, 8'hFF);
      rd(CTI_ADDR_IRQ_EN, 8'h1F);
      $display("test reset and select done");
      // pass indication in both modes
      rx_fwd_map[0] = 4'h3;
      rx_enabled = 4'h3;
      rx_valid = 4'h1;
      tx_cfg[0].pass_all = 1'b1;
      tick();
      chk("tx_pass0", {7'h00, tx_pass[0]}, 8'h00);
      tx_cfg[0].pass_all = 1'b0;
      tick();
      chk("tx_pass0", {7'h00, tx_pass[0]}, 8'h01);
      rd(CTI_ADDR_LIVE_STS, 8'h01);
      chk_irq(1'b1);
      rd(CTI_ADDR_IRQ_ST, 8'h01);
      chk_irq(1'b0);
      $display("test pass done");
      // synchronized flag gated by its enable
      tx_cfg[0].sync_ok = 1'b1;
      tick();
      chk("tx_sync0", {7'h00, tx_sync[0]}, 8'h00);
      rd(CTI_ADDR_IRQ_ST, 8'h00);
      tx_cfg[0].sync_en = 1'b1;
      tick();
      rd(CTI_ADDR_LIVE_STS, 8'h03);
      rd(CTI_ADDR_IRQ_ST, 8'h04);
      tx_cfg[0].sync_ok = 1'b0;
      tick();
      rd(CTI_ADDR_IRQ_ST, 8'h00);
      $display("test sync done");
      // each event source alone: masked, then unmasked, then read-cleared
      for (int b = 3; b >= 0; b--) begin
         wr(CTI_ADDR_IRQ_EN, 8'h1F ^ (8'h01 << b));
         @(negedge sys_clk);
         case (b)
            3: tx_cfg[0].sync_err = 1'b1;
            2: tx_cfg[0].sync_ok = 1'b1;
            1: rx_valid[0] = 1'b0;
            default: rx_valid[0] = 1'b1;
         endcase
         @(negedge sys_clk);
         tx_cfg[0].sync_err = 1'b0;
         tick();
         chk_irq(1'b0);
         wr(CTI_ADDR_IRQ_EN, 8'h01 << b);
         chk_irq(1'b1);
         rd(CTI_ADDR_IRQ_ST, 8'h01 << b);
         chk_irq(1'b0);
      end
      $display("test event gating done");
      // forwarded receive-port interrupt
      wr(CTI_ADDR_IRQ_EN, 8'h00);
      rx_irq = 4'h4;
      tick();
      rd(CTI_ADDR_IRQ_ST, 8'h00);
      rx_irq = 4'h1;
      tick();
      rd(CTI_ADDR_IRQ_ST, 8'h10);
      chk_irq(1'b0);
      wr(CTI_ADDR_IRQ_EN, 8'h10);
      chk_irq(1'b1);
      rd(CTI_ADDR_IRQ_ST, 8'h10);
      rx_irq = 4'h0;
      tick();
      rd(CTI_ADDR_IRQ_ST, 8'h00);
      $display("test forwarded interrupt done");
      // event in the same cycle as a clearing read must survive
      @(negedge sys_clk);
      req = '{wr:1'b0, rd:1'b1, addr:CTI_ADDR_IRQ_ST, wdata:8'h00};
      tx_cfg[0].sync_err = 1'b1;
      @(negedge sys_clk);
      req = '0;
      tx_cfg[0].sync_err = 1'b0;
      rd(CTI_ADDR_IRQ_ST, 8'h08);
      $display("test read collision done");
      // second port untouched, writes to status ignored, unmapped places read zero
      wr(CTI_ADDR_PORT_SEL, 8'h01);
      wr(CTI_ADDR_IRQ_ST, 8'hFF);
      rd(CTI_ADDR_IRQ_ST, 8'h00);
      rd(CTI_ADDR_IRQ_EN, 8'h0A);
      rd(8'h50, 8'h00);
      chk("tx_pass1", {7'h00, tx_pass[1]}, 8'h00);
      chk("tx_sync1", {7'h00, tx_sync[1]}, 8'h00);
      // port 1 alone sees receive port 2; port 0 does not forward it
      rx_fwd_map[1] = 4'h4;
      rx_irq = 4'h4;
      wr(CTI_ADDR_IRQ_EN, 8'h10);
      chk("tx_irq1", {7'h00, tx_irq[1]}, 8'h01);
      chk_irq(1'b0);
      rd(CTI_ADDR_IRQ_ST, 8'h10);
      rx_irq = 4'h0;
      tick();
      chk("tx_irq1", {7'h00, tx_irq[1]}, 8'h00);
      $display("test port isolation done");
      give_verdict();
   end
endmodule
